// *** logic/char_lcd_defs.svh ***
// Constants for the character display host port
`ifndef CHAR_LCD_DEFS_SVH
`define CHAR_LCD_DEFS_SVH

// -----------------------------------------------------------------------
// Serial link
// -----------------------------------------------------------------------
`define SLAVE_ADDR_BASE     7'h3c
`define CTRL_CONT_BIT       7
`define CTRL_SEL_BIT        6
`define LINK_BIT_LAST       4'h7
`define LINK_BIT_ACK        4'h8

// -----------------------------------------------------------------------
// Display and glyph RAM
// -----------------------------------------------------------------------
`define DISP_DEPTH          80
`define GLYPH_DEPTH         64
`define ONE_LINE_LAST       7'h4f
`define LINE_ONE_LAST       7'h27
`define LINE_TWO_FIRST      7'h40
`define LINE_TWO_LAST       7'h67
`define LINE_LEN            7'd40
`define GLYPH_LAST          7'h3f

// -----------------------------------------------------------------------
// Instruction codes and reset values
// -----------------------------------------------------------------------
`define INSTR_CLEAR         8'h01
`define RESET_BUS_WIDTH     1'b1
`define RESET_TWO_LINE      1'b0
`define RESET_INCREMENT     1'b1

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define CLK_SYS_MHZ         40
`define BUSY_TIME_NS        1000

`endif

// *** logic/char_lcd_pkg.sv ***
// Types for the character display host port
package char_lcd_pkg;

    typedef enum logic [2:0] {
        LINK_ADDR,
        LINK_CTRL,
        LINK_ONE,
        LINK_STREAM,
        LINK_IGNORE
    } link_phase_type;

    typedef enum logic {
        TARGET_DISPLAY,
        TARGET_GLYPH
    } ram_target_type;

endpackage

// *** logic/char_lcd_host_port.sv ***
// Host port of a character display controller: serial write link and parallel bus
//
// Function
// - Parallel bus works 4-bit or 8-bit per the bus width bit.
// - Two 8-bit holding registers: instruction and data.
// - After a data read, data holding refills from next RAM address.
// - After a data write, data holding is copied into selected RAM.
// - Instruction holding register is never readable.
// - Parallel select/direction decode: instr write, status read, data write, data read.
// - Serial link accepts writes only; only output is acknowledge.
// - Responds to one strap-selected 7-bit address 0111100..0111111.
// - Data falling with clock high is start; stop is not detected, the next start restarts the link.
// - Data stays stable while clock high, else start or stop.
// - Addressed device acknowledges each byte low on ninth clock high.
// - Address mismatch: ignore transfer, no acknowledge.
// - Control/data byte pairs; control with continuation clear makes rest data.
// - Select 1: bytes stored in display or glyph RAM per target, pointer advances.
// - Select 0: bytes decoded as instructions.
// - Busy flag set while executing; new instruction refused meanwhile.
// - Pointer loaded by instruction; steps by one after each data read or data write.
// - Display RAM holds 80 bytes, unused ones free storage.
// - Two-line mode: second line start not contiguous with first end.
`timescale 1ns/1ps
`include "char_lcd_defs.svh"

module char_lcd_host_port
    import char_lcd_pkg::*;
#(
    parameter int BUSY_NS = `BUSY_TIME_NS
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [1:0] addr_strap,
    input  wire logic       enable_in,
    input  wire logic       register_select,
    input  wire logic       read_write,
    input  wire logic [7:0] par_data_in,
    output logic      [7:0] par_data_out,
    output logic            par_data_oe,
    input  wire logic       three_line_select,
    input  wire logic [6:0] disp_rd_addr,
    output logic      [7:0] disp_rd_data,
    output logic            operation_pending_flag,
    output logic            bus_width_bit,
    output logic      [6:0] ram_pointer
);

    localparam int BUSY_CYCLES = (BUSY_NS * `CLK_SYS_MHZ + 999) / 1000;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [6:0] disp_index(input logic [6:0] addr, input logic two);
        disp_index = (two && addr[6]) ? 7'(addr - `LINE_TWO_FIRST + `LINE_LEN) : addr;
    endfunction

    function automatic logic [6:0] ptr_step(input logic [6:0] p, input logic inc,
                                            input logic two, input logic glyph);
        logic [6:0] nxt;
        nxt = inc ? 7'(p + 7'd1) : 7'(p - 7'd1);
        if (glyph) begin
            ptr_step = nxt & `GLYPH_LAST;
        end else if (two) begin
            if (inc && p == `LINE_ONE_LAST) begin
                ptr_step = `LINE_TWO_FIRST;
            end else if (inc && p == `LINE_TWO_LAST) begin
                ptr_step = 7'h00;
            end else if (!inc && p == 7'h00) begin
                ptr_step = `LINE_TWO_LAST;
            end else if (!inc && p == `LINE_TWO_FIRST) begin
                ptr_step = `LINE_ONE_LAST;
            end else begin
                ptr_step = nxt;
            end
        end else if (inc && p == `ONE_LINE_LAST) begin
            ptr_step = 7'h00;
        end else if (!inc && p == 7'h00) begin
            ptr_step = `ONE_LINE_LAST;
        end else begin
            ptr_step = nxt;
        end
    endfunction

    // -------------------------------------------------------------------
    // Serial link: start detection on the data line
    // -------------------------------------------------------------------
    logic start_tog_q;

    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_tog_q <= 1'b0;
        end else if (scl_in) begin
            start_tog_q <= ~start_tog_q;
        end
    end

    // -------------------------------------------------------------------
    // Serial link: bit engine on the serial clock
    // -------------------------------------------------------------------
    logic           bit_rise_q;
    logic           start_seen_q;
    logic     [1:0] strap_s1_q;
    logic     [1:0] strap_s2_q;
    logic     [6:0] shift_q;
    logic     [3:0] bit_cnt_q;
    logic           ack_q;
    link_phase_type phase_q;
    logic           sel_q;
    logic     [7:0] link_byte_q;
    logic           link_sel_q;
    logic           link_tog_q;

    wire            start_pending = start_tog_q ^ start_seen_q;
    wire      [7:0] rx_byte       = {shift_q, bit_rise_q};
    wire      [6:0] own_addr      = `SLAVE_ADDR_BASE | {5'h00, strap_s2_q};
    wire            addr_hit      = rx_byte[7:1] == own_addr && !rx_byte[0];
    wire            byte_done     = bit_cnt_q == `LINK_BIT_LAST;
    wire            is_data_phase = phase_q == LINK_ONE || phase_q == LINK_STREAM;

    always_ff @(posedge scl_in or negedge rst_n) begin
        if (!rst_n) begin
            bit_rise_q <= 1'b1;
        end else begin
            bit_rise_q <= sda_in;
        end
    end

    always_ff @(negedge scl_in or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_q <= 2'b00;
            strap_s2_q <= 2'b00;
        end else begin
            strap_s1_q <= addr_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    always_ff @(negedge scl_in or negedge rst_n) begin
        if (!rst_n) begin
            start_seen_q <= 1'b0;
            shift_q      <= 7'h00;
            bit_cnt_q    <= 4'h0;
            ack_q        <= 1'b0;
            phase_q      <= LINK_IGNORE;
            sel_q        <= 1'b0;
        end else if (start_pending) begin
            start_seen_q <= start_tog_q;
            bit_cnt_q    <= 4'h0;
            ack_q        <= 1'b0;
            phase_q      <= LINK_ADDR;
        end else if (bit_cnt_q == `LINK_BIT_ACK) begin
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b0;
        end else begin
            shift_q   <= rx_byte[6:0];
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            if (byte_done) begin
                case (phase_q)
                    LINK_ADDR: begin
                        ack_q   <= addr_hit;
                        phase_q <= addr_hit ? LINK_CTRL : LINK_IGNORE;
                    end
                    LINK_CTRL: begin
                        ack_q   <= 1'b1;
                        sel_q   <= rx_byte[`CTRL_SEL_BIT];
                        phase_q <= rx_byte[`CTRL_CONT_BIT] ? LINK_ONE : LINK_STREAM;
                    end
                    LINK_ONE: begin
                        ack_q   <= 1'b1;
                        phase_q <= LINK_CTRL;
                    end
                    LINK_STREAM: begin
                        ack_q <= 1'b1;
                    end
                    default: begin
                        ack_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Received byte handed to the system clock by a toggle
    always_ff @(negedge scl_in or negedge rst_n) begin
        if (!rst_n) begin
            link_byte_q <= 8'h00;
            link_sel_q  <= 1'b0;
            link_tog_q  <= 1'b0;
        end else if (!start_pending && byte_done && is_data_phase) begin
            link_byte_q <= rx_byte;
            link_sel_q  <= sel_q;
            link_tog_q  <= ~link_tog_q;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = ack_q;

    // -------------------------------------------------------------------
    // Crossings into the system clock
    // -------------------------------------------------------------------
    logic        tog_s1_q;
    logic        tog_s2_q;
    logic        tog_s3_q;
    logic        en_s1_q;
    logic        en_s2_q;
    logic        en_s3_q;
    logic [9:0]  pin_s1_q;
    logic [9:0]  pin_s2_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
            en_s1_q  <= 1'b0;
            en_s2_q  <= 1'b0;
            en_s3_q  <= 1'b0;
            pin_s1_q <= 10'h000;
            pin_s2_q <= 10'h000;
        end else begin
            tog_s1_q <= link_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
            en_s1_q  <= enable_in;
            en_s2_q  <= en_s1_q;
            en_s3_q  <= en_s2_q;
            pin_s1_q <= {register_select, read_write, par_data_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // -------------------------------------------------------------------
    // Parallel bus decode
    // -------------------------------------------------------------------
    logic           nib_q;
    logic     [3:0] nib_hi_q;
    logic     [7:0] data_holding_q;
    logic     [7:0] instruction_holding_q;
    logic     [6:0] pointer_q;
    logic           busy_q;
    logic    [15:0] busy_cnt_q;
    logic           bus_width_q;
    logic           two_line_q;
    logic           increment_q;
    ram_target_type target_q;
    logic           refill_q;
    logic     [7:0] par_dout_q;
    logic     [7:0] disp_rd_q;

    wire            link_fire   = tog_s2_q ^ tog_s3_q;
    wire            par_rs      = pin_s2_q[9];
    wire            par_rw      = pin_s2_q[8];
    wire      [7:0] par_d       = pin_s2_q[7:0];
    wire            en_fall     = en_s3_q && !en_s2_q;
    wire            four_bit    = !bus_width_q;
    wire            par_last    = !four_bit || nib_q;
    wire      [7:0] par_wbyte   = four_bit ? {nib_hi_q, par_d[7:4]} : par_d;
    wire            par_wr_fire = en_fall && !par_rw && par_last;
    wire            par_rd_fire = en_fall && par_rw && par_rs && par_last;
    wire            wr_fire     = link_fire || par_wr_fire;
    wire            wr_sel      = link_fire ? link_sel_q : par_rs;
    wire      [7:0] wr_byte     = link_fire ? link_byte_q : par_wbyte;
    wire            instr_ok    = wr_fire && !wr_sel && !busy_q;
    wire            data_wr     = wr_fire && wr_sel;
    wire            two_map     = two_line_q && !three_line_select;
    wire            glyph       = target_q == TARGET_GLYPH;
    wire      [6:0] ptr_next    = ptr_step(pointer_q, increment_q, two_map, glyph);
    wire      [7:0] status_byte = {busy_q, pointer_q};
    wire      [7:0] rd_byte     = par_rs ? data_holding_q : status_byte;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            nib_q    <= 1'b0;
            nib_hi_q <= 4'h0;
        end else if (en_fall) begin
            nib_q    <= four_bit && !nib_q;
            nib_hi_q <= par_d[7:4];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            par_dout_q <= 8'h00;
        end else begin
            par_dout_q <= (four_bit && nib_q) ? {rd_byte[3:0], 4'h0} : rd_byte;
        end
    end

    assign par_data_out = par_dout_q;
    assign par_data_oe  = en_s2_q && par_rw;

    // -------------------------------------------------------------------
    // Display and glyph RAM
    // -------------------------------------------------------------------
    logic [7:0] disp_mem [`DISP_DEPTH];
    logic [7:0] glyph_mem [`GLYPH_DEPTH];

    wire  [6:0] disp_idx  = disp_index(pointer_q, two_map);
    wire  [6:0] view_idx  = disp_index(disp_rd_addr, two_map);
    wire  [7:0] ram_value = glyph ? glyph_mem[pointer_q[5:0]] : disp_mem[disp_idx];

    always_ff @(posedge clk_sys) begin
        if (data_wr) begin
            if (glyph) begin
                glyph_mem[pointer_q[5:0]] <= wr_byte;
            end else if (disp_idx < 7'(`DISP_DEPTH)) begin
                disp_mem[disp_idx] <= wr_byte;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            disp_rd_q <= 8'h00;
        end else if (view_idx < 7'(`DISP_DEPTH)) begin
            disp_rd_q <= disp_mem[view_idx];
        end else begin
            disp_rd_q <= 8'h00;
        end
    end

    assign disp_rd_data = disp_rd_q;

    // -------------------------------------------------------------------
    // Holding registers, pointer and instruction decode
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_holding_q        <= 8'h00;
            instruction_holding_q <= 8'h00;
            refill_q              <= 1'b0;
        end else begin
            refill_q <= par_rd_fire;
            if (data_wr) begin
                data_holding_q <= wr_byte;
            end else if (refill_q) begin
                data_holding_q <= ram_value;
            end
            if (instr_ok) begin
                instruction_holding_q <= wr_byte;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pointer_q   <= 7'h00;
            target_q    <= TARGET_DISPLAY;
            bus_width_q <= `RESET_BUS_WIDTH;
            two_line_q  <= `RESET_TWO_LINE;
            increment_q <= `RESET_INCREMENT;
        end else if (instr_ok) begin
            if (wr_byte[7]) begin
                target_q  <= TARGET_DISPLAY;
                pointer_q <= wr_byte[6:0];
            end else if (wr_byte[7:6] == 2'b01) begin
                target_q  <= TARGET_GLYPH;
                pointer_q <= {1'b0, wr_byte[5:0]};
            end else if (wr_byte[7:5] == 3'b001) begin
                bus_width_q <= wr_byte[4];
                two_line_q  <= wr_byte[3];
            end else if (wr_byte[7:2] == 6'b000001) begin
                increment_q <= wr_byte[1];
            end else if (wr_byte == `INSTR_CLEAR) begin
                target_q    <= TARGET_DISPLAY;
                pointer_q   <= 7'h00;
                increment_q <= 1'b1;
            end else if (wr_byte[7:1] == 7'h01) begin
                target_q  <= TARGET_DISPLAY;
                pointer_q <= 7'h00;
            end
        end else if (data_wr || par_rd_fire) begin
            pointer_q <= ptr_next;
        end
    end

    // -------------------------------------------------------------------
    // Busy timer
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= 16'h0000;
        end else if (instr_ok || data_wr) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= 16'(BUSY_CYCLES - 1);
        end else if (busy_cnt_q != 16'h0000) begin
            busy_cnt_q <= 16'(busy_cnt_q - 16'h0001);
        end else begin
            busy_q <= 1'b0;
        end
    end

    assign operation_pending_flag = busy_q;
    assign bus_width_bit          = bus_width_q;
    assign ram_pointer            = pointer_q;

endmodule

// *** testbench/char_lcd_host_port_properties.sv ***
// Concurrent checks on the host port pins
`timescale 1ns/1ps
module char_lcd_host_port_checker #(
    parameter int BUSY_NS = 1000
) (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       enable_in,
    input wire logic       read_write,
    input wire logic       par_data_oe,
    input wire logic       operation_pending_flag,
    input wire logic       bus_width_bit,
    input wire logic [6:0] ram_pointer,
    input wire logic [6:0] disp_rd_addr,
    input wire logic [7:0] disp_rd_data
);
    localparam int BUSY_CYC = BUSY_NS * 40 / 1000;
    logic [15:0] run_q;

    // ------------------------------------------------------------
    // Busy run length and properties
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= operation_pending_flag ? run_q + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_strobe_quiet; !enable_in [*4]; endsequence
    sequence s_write_dir; !read_write [*4]; endsequence
    sequence s_busy_start; $rose(operation_pending_flag); endsequence

    property p_drive_low; sda_out == 1'b0; endproperty
    property p_ack_short; $rose(sda_oe) |-> ##[1:8] !sda_oe; endproperty
    property p_busy_hold; s_busy_start |-> operation_pending_flag [*8]; endproperty
    property p_busy_ends; s_busy_start |-> ##[1:1000] !operation_pending_flag; endproperty
    property p_busy_len; $fell(operation_pending_flag) |-> run_q >= BUSY_CYC - 2; endproperty
    property p_oe_idle; s_strobe_quiet |-> !par_data_oe; endproperty
    property p_oe_write; s_write_dir |-> !par_data_oe; endproperty
    property p_ptr_cause;
        $changed(ram_pointer) && !$past(par_data_oe) && !$past(par_data_oe, 2)
            && !$past(par_data_oe, 3) |-> ##[0:1] operation_pending_flag;
    endproperty
    property p_width_cause; $changed(bus_width_bit) |-> ##[0:1] operation_pending_flag; endproperty
    property p_outside_zero; $past(disp_rd_addr) >= 7'h68 |-> disp_rd_data == 8'h00; endproperty

    a_drive_low: assert property (p_drive_low)
        else $error("serial drive value not low");
    a_ack_short: assert property (p_ack_short)
        else $error("acknowledge held too long");
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped early");
    a_busy_ends: assert property (p_busy_ends)
        else $error("busy never ends");
    a_busy_len: assert property (p_busy_len)
        else $error("busy run too short");
    a_oe_idle: assert property (p_oe_idle)
        else $error("parallel drive without strobe");
    a_oe_write: assert property (p_oe_write)
        else $error("parallel drive during write");
    a_ptr_cause: assert property (p_ptr_cause)
        else $error("pointer moved without cause");
    a_width_cause: assert property (p_width_cause)
        else $error("bus width moved without instruction");
    a_outside_zero: assert property (p_outside_zero)
        else $error("view outside RAM not zero");
endmodule

bind char_lcd_host_port char_lcd_host_port_checker #(.BUSY_NS(BUSY_NS)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .sda_out(sda_out), .sda_oe(sda_oe),
    .enable_in(enable_in), .read_write(read_write), .par_data_oe(par_data_oe),
    .operation_pending_flag(operation_pending_flag), .bus_width_bit(bus_width_bit),
    .ram_pointer(ram_pointer), .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data)
);

// *** testbench/i2c_host_model.sv ***
// Serial bus master model for the host port link
`timescale 1ns/1ps
module i2c_host_model (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    localparam int HALF = 24;
    logic ack_seen;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ack_seen = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame tasks, clock stands still between frames
    // ------------------------------------------------------------
    task automatic open_frame;
        #7;
        sda_low = 1'b1;
        #HALF;
        scl = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #(HALF / 2) sda_low = ~b[i];
            #(HALF / 2) scl = 1'b1;
            #HALF scl = 1'b0;
        end
        #(HALF / 2) sda_low = 1'b0;
        #(HALF / 2) scl = 1'b1;
        #2 ack_seen = ~sda_line;
        #(HALF - 4) ack_seen = ack_seen & ~sda_line;
        #2 scl = 1'b0;
    endtask

    task automatic close_frame;
        #(HALF / 2) sda_low = 1'b1;
        #(HALF / 2) scl = 1'b1;
        #HALF sda_low = 1'b0;
        #HALF;
    endtask
endmodule

// *** testbench/char_lcd_i2c_host_port_tb_top.sv ***
// Self-checking bench of the character display host port
`timescale 1ns/1ps
module char_lcd_i2c_host_port_tb_top;
    typedef struct {logic [7:0] v; int k;} note_type;
    logic       clk_sys, rst_n, host_low, enable_in, register_select, read_write;
    logic       three_line_select;
    logic [1:0] addr_strap;
    logic [7:0] par_data_in;
    logic [6:0] disp_rd_addr;
    wire        scl, sda_line, sda_out, sda_oe, par_data_oe, busy, bus_width_bit;
    wire  [7:0] par_data_out, disp_rd_data;
    wire  [6:0] ram_pointer;
    note_type   exp_q[$];
    event       look_ev;
    int         err_count = 0;
    int         checks_done = 0;

    assign sda_line = ~(host_low | (sda_oe & ~sda_out));

    i2c_host_model host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));

    char_lcd_host_port #(.BUSY_NS(1000)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
        .enable_in(enable_in), .register_select(register_select),
        .read_write(read_write), .par_data_in(par_data_in),
        .par_data_out(par_data_out), .par_data_oe(par_data_oe),
        .three_line_select(three_line_select), .disp_rd_addr(disp_rd_addr),
        .disp_rd_data(disp_rd_data), .operation_pending_flag(busy),
        .bus_width_bit(bus_width_bit), .ram_pointer(ram_pointer)
    );

    // ------------------------------------------------------------
    // Expectation queue, monitor and closing
    // ------------------------------------------------------------
    task automatic expect_val(input int k, input logic [7:0] v);
        @(negedge clk_sys);
        exp_q.push_back(note_type'{v, k});
        -> look_ev;
    endtask

    function automatic logic [7:0] observe(input int k);
        case (k)
            0: return par_data_out;
            1: return disp_rd_data;
            2: return {1'b0, ram_pointer};
            3: return {7'h00, host.ack_seen};
            default: return {busy, bus_width_bit, par_data_oe, sda_oe, 4'h0};
        endcase
    endfunction

    task automatic compare_val(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    initial begin
        note_type n;
        forever begin
            @(look_ev);
            while (exp_q.size() > 0) begin
                n = exp_q.pop_front();
                compare_val(n.v, observe(n.k));
            end
        end
    end

    task automatic final_report;
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] b, input logic [7:0] a);
        host.put_byte(b);
        expect_val(3, a);
    endtask

    task automatic frame2(input logic [7:0] c, input logic [7:0] b);
        host.open_frame();
        send(8'h7c, 8'h01);
        send(c, 8'h01);
        send(b, 8'h01);
        host.close_frame();
        repeat (50) @(posedge clk_sys);
    endtask

    task automatic par(input logic rs, input logic rw, input logic [7:0] d,
                       input int k, input logic [7:0] e);
        @(posedge clk_sys);
        register_select <= rs;
        read_write <= rw;
        par_data_in <= d;
        repeat (2) @(posedge clk_sys);
        enable_in <= 1'b1;
        repeat (5) @(posedge clk_sys);
        if (k >= 0) expect_val(k, e);
        @(posedge clk_sys);
        enable_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic peek(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        disp_rd_addr <= a;
        repeat (2) @(posedge clk_sys);
        expect_val(1, e);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        #500000;
        err_count++;
        final_report();
    end

    initial begin
        logic [7:0] d [4];
        int         seed_ok;
        rst_n = 1'b0;
        enable_in = 1'b0;
        register_select = 1'b0;
        read_write = 1'b0;
        par_data_in = 8'h00;
        addr_strap = 2'h2;
        three_line_select = 1'b0;
        disp_rd_addr = 7'h00;
        seed_ok = $urandom(32'h389c);
        foreach (d[i]) d[i] = 8'($urandom);
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        expect_val(4, 8'h40);
        expect_val(2, 8'h00);
        for (int s = 0; s < 4; s++) begin
            host.open_frame();
            send(8'h78 | 8'(s << 1), 8'(s == 2));
            send(8'h00, 8'(s == 2));
            send(8'h01, 8'(s == 2));
            host.close_frame();
        end
        repeat (50) @(posedge clk_sys);
        host.open_frame();
        send(8'h7d, 8'h00);
        send(8'h40, 8'h00);
        host.close_frame();
        for (int i = 0; i < 2; i++) begin
            frame2(8'h00, i ? 8'h38 : 8'h28);
            expect_val(4, i ? 8'h40 : 8'h00);
            if (i == 0) begin
                par(1'b0, 1'b0, 8'h80, -1, 8'h00);
                par(1'b0, 1'b0, 8'h60, -1, 8'h00);
                expect_val(2, 8'h06);
            end
        end
        host.open_frame();
        send(8'h7c, 8'h01);
        send(8'h80, 8'h01);
        send(8'ha6, 8'h01);
        send(8'hc0, 8'h01);
        send(d[0], 8'h01);
        send(8'h40, 8'h01);
        send(d[1], 8'h01);
        send(d[2], 8'h01);
        host.close_frame();
        repeat (50) @(posedge clk_sys);
        expect_val(2, 8'h41);
        par(1'b1, 1'b0, d[3], -1, 8'h00);
        par(1'b0, 1'b1, 8'h00, 0, 8'hc2);
        par(1'b0, 1'b0, 8'h80, -1, 8'h00);
        repeat (50) @(posedge clk_sys);
        par(1'b0, 1'b1, 8'h00, 0, 8'h42);
        par(1'b0, 1'b0, 8'ha6, -1, 8'h00);
        repeat (50) @(posedge clk_sys);
        par(1'b1, 1'b1, 8'h00, -1, 8'h00);
        par(1'b1, 1'b1, 8'h00, 0, d[1]);
        expect_val(2, 8'h40);
        peek(7'h26, d[0]);
        peek(7'h27, d[1]);
        peek(7'h40, d[2]);
        peek(7'h41, d[3]);
        peek(7'h70, 8'h00);
        repeat (2) @(posedge clk_sys);
        final_report();
    end
endmodule
